// ---- core/diag_pkg.sv ----
// Purpose: Shared constants and carriers for the half-bridge diagnosis block.
// Assumes: Ten bridges split into a low group of six and a high group of four.
// Notes: Bit positions apply to both diagnosis words and to the control word.
package diag_pkg;

  localparam int unsigned NUM_BRIDGES = 10;
  localparam int unsigned LOW_BRIDGES = 6;
  localparam int unsigned HIGH_BRIDGES = 4;
  localparam int unsigned WORD_W = 16;

  // Diagnosis word fields.
  localparam int unsigned OC_BIT = 15;
  localparam int unsigned PSF_BIT = 14;
  localparam int unsigned OL_BIT = 13;
  localparam int unsigned ACT_LSB = 7;
  localparam int unsigned SIDE_LSB = 1;
  localparam int unsigned TW_BIT = 0;

  // Control word fields.
  localparam int unsigned CTRL_SRR_BIT = 15;
  localparam int unsigned CTRL_ADDR_BIT = 14;
  localparam int unsigned CTRL_OLSD_BIT = 13;
  localparam int unsigned CTRL_ACT_LSB = 7;
  localparam int unsigned CTRL_CONF_LSB = 1;

  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [NUM_BRIDGES-1:0] BRIDGE_RESET = 10'h000;

  // Analog detector and driver feedback, all asynchronous to the core clock.
  typedef struct packed {
    logic [NUM_BRIDGES-1:0] overcurrent;
    logic [NUM_BRIDGES-1:0] open_load;
    logic [NUM_BRIDGES-1:0] high_side_switch;
    logic [NUM_BRIDGES-1:0] low_side_switch;
    logic load_supply_fault;
    logic temp_warning;
  } sense_s;

  // Gate commands to the output stages.
  typedef struct packed {
    logic [NUM_BRIDGES-1:0] high_side_switch;
    logic [NUM_BRIDGES-1:0] low_side_switch;
  } drive_s;

  typedef struct packed {
    logic [WORD_W-1:0] group_low;
    logic [WORD_W-1:0] group_high;
  } diag_s;

endpackage

// ---- core/sync_stages.sv ----
// Purpose: Two flip-flop synchroniser for levels entering the core clock.
// Assumes: Each bit is an independent level or a toggle.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
module sync_stages #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// ---- core/half_bridge_diag_status.sv ----
// Purpose: Builds the two diagnosis words and the protective switch-off of ten bridges.
// Assumes: The serial shifter hands over each received control word with a done pulse
// on the link clock, and the frame ends on the rising edge of chip_select_n.
// Notes: Diagnosis words are refreshed every core cycle for the shifter to load.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// How it works
// R1 - Word 0 holds overcurrent at 15, supply fail at 14, open load at 13, active of bridges 6..1 at 12..7, side of bridges 6..1 at 6..1 and temperature warning at 0.
// R2 - Word 1 shares bits 15, 14, 13 and 0, holds active of bridges 10..7 at 10..7 and side at 4..1, and reads zero in 12, 11, 6 and 5.
// R3 - Any overload, short or cross-current in a group sets that word's overcurrent flag.
// R4 - An overcurrent latches the flag and forces the affected bridge off.
// R5 - A latched overcurrent clears only on a status-reset request or power-on reset.
// R6 - A load supply fault sets the global supply-fail flag and switches every bridge off.
// R7 - The supply-fail flag clears by itself once the load supply is back in range.
// R8 - A true open load or underload in a group sets and latches that word's open-load flag.
// R9 - An open load switches its bridge off only while the group's open-load shutdown enable is high.
// R10 - A latched open load clears only on a status-reset request or power-on reset.
// R11 - Each active bit is high while its bridge drives and low while it is high impedance.
// R12 - A control word with status-reset high clears the matching word's errors at the rising edge of chip select.
// R13 - Each side bit is high with high side on and low side off, and low for the opposite.
// R14 - The first diagnosis word after start-up shows only supply fail and temperature warning.
// R15 - Active and side bits come from the real driver state, not the commanded values.
module half_bridge_diag_status #(
  parameter int unsigned NUM_BRIDGES = diag_pkg::NUM_BRIDGES,
  parameter int unsigned LOW_BRIDGES = diag_pkg::LOW_BRIDGES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic chip_select_n,
  input wire logic [diag_pkg::WORD_W-1:0] link_ctrl_word,
  input wire logic link_word_done,
  input wire diag_pkg::sense_s sense,
  output diag_pkg::drive_s drive,
  output diag_pkg::diag_s diag
);

  localparam int unsigned W = diag_pkg::WORD_W;
  localparam int unsigned SENSE_W = $bits(diag_pkg::sense_s);

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: hold the last received control word and flag it by a toggle.

  logic [W-1:0] hold_q;
  logic [W-1:0] hold_d;
  logic tgl_q;
  logic tgl_d;

  always_comb begin
    hold_d = hold_q;
    tgl_d = tgl_q;
    if (link_word_done) begin
      hold_d = link_ctrl_word;
      tgl_d = ~tgl_q;
    end
  end

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      hold_q <= diag_pkg::WORD_RESET;
      tgl_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      tgl_q <= tgl_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Crossings into the core domain.

  logic tgl_s;
  logic csn_s;
  diag_pkg::sense_s sense_s;

  sync_stages #(
    .WIDTH(1),
    .RESET_VAL(1'b0)
  ) u_tgl_sync (
    .clk(core_clk),
    .reset(reset),
    .async_in(tgl_q),
    .sync_out(tgl_s)
  );

  // Chip select idles high, so its synchroniser resets high to avoid a false edge.
  sync_stages #(
    .WIDTH(1),
    .RESET_VAL(1'b1)
  ) u_csn_sync (
    .clk(core_clk),
    .reset(reset),
    .async_in(chip_select_n),
    .sync_out(csn_s)
  );

  sync_stages #(
    .WIDTH(SENSE_W),
    .RESET_VAL('0)
  ) u_sense_sync (
    .clk(core_clk),
    .reset(reset),
    .async_in(sense),
    .sync_out(sense_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Control word capture, applied at the end of the frame.

  logic tgl_prev_q;
  logic tgl_prev_d;
  logic csn_prev_q;
  logic csn_prev_d;
  logic [W-1:0] pend_q;
  logic [W-1:0] pend_d;
  logic pend_valid_q;
  logic pend_valid_d;
  logic first_q;
  logic first_d;
  logic open_load_shutdown_enable_q [2];
  logic open_load_shutdown_enable_d [2];
  logic [NUM_BRIDGES-1:0] cmd_act_q;
  logic [NUM_BRIDGES-1:0] cmd_act_d;
  logic [NUM_BRIDGES-1:0] cmd_conf_q;
  logic [NUM_BRIDGES-1:0] cmd_conf_d;
  logic srr_lo;
  logic srr_hi;
  logic word_event;
  logic csn_rise;
  logic [W-1:0] word;
  logic word_ok;

  always_comb begin
    word_event = tgl_s ^ tgl_prev_q;
    csn_rise = csn_s & ~csn_prev_q;
    // The held word is quiet here: it loads only on a done pulse and none comes until the next
    // frame, so the multi-bit copy is safe once the toggle has been seen.
    word = word_event ? hold_q : pend_q;
    word_ok = word_event | pend_valid_q;
    tgl_prev_d = tgl_s;
    csn_prev_d = csn_s;
    pend_d = word;
    pend_valid_d = word_ok & ~csn_rise;
    first_d = first_q & ~csn_rise;
    open_load_shutdown_enable_d = open_load_shutdown_enable_q;
    cmd_act_d = cmd_act_q;
    cmd_conf_d = cmd_conf_q;
    srr_lo = 1'b0;
    srr_hi = 1'b0;
    if (csn_rise && word_ok) begin
      if (!word[diag_pkg::CTRL_ADDR_BIT]) begin
        srr_lo = word[diag_pkg::CTRL_SRR_BIT]; // R12
        open_load_shutdown_enable_d[0] = word[diag_pkg::CTRL_OLSD_BIT];
        for (int i = 0; i < LOW_BRIDGES; i++) begin
          cmd_act_d[i] = word[diag_pkg::CTRL_ACT_LSB + i];
          cmd_conf_d[i] = word[diag_pkg::CTRL_CONF_LSB + i];
        end
      end else begin
        srr_hi = word[diag_pkg::CTRL_SRR_BIT]; // R12
        open_load_shutdown_enable_d[1] = word[diag_pkg::CTRL_OLSD_BIT];
        for (int i = LOW_BRIDGES; i < NUM_BRIDGES; i++) begin
          cmd_act_d[i] = word[diag_pkg::CTRL_ACT_LSB + i - LOW_BRIDGES];
          cmd_conf_d[i] = word[diag_pkg::CTRL_CONF_LSB + i - LOW_BRIDGES];
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tgl_prev_q <= 1'b0;
      csn_prev_q <= 1'b1;
      pend_q <= diag_pkg::WORD_RESET;
      pend_valid_q <= 1'b0;
      first_q <= 1'b1;
      open_load_shutdown_enable_q <= '{1'b0, 1'b0};
      cmd_act_q <= diag_pkg::BRIDGE_RESET;
      cmd_conf_q <= diag_pkg::BRIDGE_RESET;
    end else begin
      tgl_prev_q <= tgl_prev_d;
      csn_prev_q <= csn_prev_d;
      pend_q <= pend_d;
      pend_valid_q <= pend_valid_d;
      first_q <= first_d;
      open_load_shutdown_enable_q <= open_load_shutdown_enable_d;
      cmd_act_q <= cmd_act_d;
      cmd_conf_q <= cmd_conf_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Error latches and protective switch-off.

  logic [NUM_BRIDGES-1:0] oc_latch_q;
  logic [NUM_BRIDGES-1:0] oc_latch_d;
  logic [NUM_BRIDGES-1:0] ol_latch_q;
  logic [NUM_BRIDGES-1:0] ol_latch_d;
  logic [NUM_BRIDGES-1:0] off;
  logic in_hi;
  logic clr;
  diag_pkg::drive_s drive_q;
  diag_pkg::drive_s drive_d;

  always_comb begin
    oc_latch_d = oc_latch_q;
    ol_latch_d = ol_latch_q;
    off = '0;
    drive_d = '0;
    for (int i = 0; i < NUM_BRIDGES; i++) begin
      in_hi = (i >= LOW_BRIDGES);
      clr = in_hi ? srr_hi : srr_lo;
      // A new fault in the clearing cycle keeps its latch set.
      oc_latch_d[i] = sense_s.overcurrent[i] | (oc_latch_q[i] & ~clr); // R4 R5
      ol_latch_d[i] = sense_s.open_load[i] | (ol_latch_q[i] & ~clr); // R8 R10
      off[i] = oc_latch_q[i] | sense_s.overcurrent[i]; // R4
      off[i] = off[i] | (ol_latch_q[i] & open_load_shutdown_enable_q[in_hi]); // R9
      off[i] = off[i] | sense_s.load_supply_fault; // R6
      if (cmd_act_q[i] && !off[i]) begin
        drive_d.high_side_switch[i] = cmd_conf_q[i];
        drive_d.low_side_switch[i] = ~cmd_conf_q[i];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      oc_latch_q <= diag_pkg::BRIDGE_RESET;
      ol_latch_q <= diag_pkg::BRIDGE_RESET;
      drive_q <= '0;
    end else begin
      oc_latch_q <= oc_latch_d;
      ol_latch_q <= ol_latch_d;
      drive_q <= drive_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Diagnosis word assembly from the real driver state.

  logic [NUM_BRIDGES-1:0] act;
  logic [NUM_BRIDGES-1:0] side;
  diag_pkg::diag_s diag_q;
  diag_pkg::diag_s diag_d;

  always_comb begin
    act = sense_s.high_side_switch | sense_s.low_side_switch; // R11 R15
    side = sense_s.high_side_switch & ~sense_s.low_side_switch; // R13 R15
    diag_d.group_low = diag_pkg::WORD_RESET;
    diag_d.group_high = diag_pkg::WORD_RESET; // R2
    diag_d.group_low[diag_pkg::PSF_BIT] = sense_s.load_supply_fault; // R6 R7
    diag_d.group_high[diag_pkg::PSF_BIT] = sense_s.load_supply_fault; // R6 R7
    diag_d.group_low[diag_pkg::TW_BIT] = sense_s.temp_warning; // R1
    diag_d.group_high[diag_pkg::TW_BIT] = sense_s.temp_warning; // R2
    // Until the first frame ends only the live supply and thermal bits show.
    if (!first_q) begin
      diag_d.group_low[diag_pkg::OC_BIT] = |oc_latch_q[LOW_BRIDGES-1:0]; // R3
      diag_d.group_high[diag_pkg::OC_BIT] = |oc_latch_q[NUM_BRIDGES-1:LOW_BRIDGES]; // R3
      diag_d.group_low[diag_pkg::OL_BIT] = |ol_latch_q[LOW_BRIDGES-1:0]; // R8
      diag_d.group_high[diag_pkg::OL_BIT] = |ol_latch_q[NUM_BRIDGES-1:LOW_BRIDGES]; // R8
      for (int i = 0; i < LOW_BRIDGES; i++) begin
        diag_d.group_low[diag_pkg::ACT_LSB + i] = act[i]; // R1 R11
        diag_d.group_low[diag_pkg::SIDE_LSB + i] = side[i]; // R1 R13
      end
      for (int i = LOW_BRIDGES; i < NUM_BRIDGES; i++) begin
        diag_d.group_high[diag_pkg::ACT_LSB + i - LOW_BRIDGES] = act[i]; // R2
        diag_d.group_high[diag_pkg::SIDE_LSB + i - LOW_BRIDGES] = side[i]; // R2
      end
    end // R14
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      diag_q.group_low <= diag_pkg::WORD_RESET;
      diag_q.group_high <= diag_pkg::WORD_RESET;
    end else begin
      diag_q <= diag_d;
    end
  end

  assign drive = drive_q;
  assign diag = diag_q;

endmodule

// ---- verif/diag_chk.sv ----
// Purpose: Concurrent checks on the diagnosis words and the switch-off.
// Assumes: Sense latency of three core edges, frame end seen on chip_select_n.
// Notes: Repetition counts leave margin over the synchroniser latency.
`timescale 1ns/1ns
module diag_chk (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire diag_pkg::sense_s sense,
  input wire diag_pkg::drive_s drive,
  input wire diag_pkg::diag_s diag
);
  logic csn_q, csn_d, framed_q, framed_d;
  logic [3:0] age_q, age_d;
  always_comb begin
    csn_d = chip_select_n;
    framed_d = framed_q | (chip_select_n & ~csn_q);
    age_d = (chip_select_n & ~csn_q) ? 4'h0 : age_q + 4'(age_q != 4'hf);
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      csn_q <= 1'b1;
      framed_q <= 1'b0;
      age_q <= 4'hf;
    end else begin
      csn_q <= csn_d;
      framed_q <= framed_d;
      age_q <= age_d;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_psf_held; sense.load_supply_fault [*6]; endsequence
  sequence s_after_frame; age_q <= 4'h8; endsequence
  a_shared_bits: assert property (diag.group_low[14] == diag.group_high[14]
    && diag.group_low[0] == diag.group_high[0]) else $error("shared bits differ");
  a_unused_zero: assert property (diag.group_high[12:11] == 2'h0
    && diag.group_high[6:5] == 2'h0) else $error("unused bits set");
  a_psf_all_off: assert property (s_psf_held |-> diag.group_low[14]
    && drive == '0) else $error("supply fail not handled");
  a_psf_self_clear: assert property (!sense.load_supply_fault [*6]
    |-> !diag.group_low[14]) else $error("supply fail stuck");
  a_oc_sets: assert property ((framed_q && |sense.overcurrent[5:0]) [*6]
    |-> diag.group_low[15]) else $error("overcurrent not flagged");
  a_oc_forces_off: assert property (($past(sense.overcurrent, 4)
    & $past(sense.overcurrent, 3)
    & (drive.high_side_switch | drive.low_side_switch)) == '0) else $error("bridge on in fault");
  a_oc_holds: assert property ($fell(diag.group_low[15]) || $fell(diag.group_high[15])
    |-> s_after_frame) else $error("overcurrent cleared without frame");
  a_ol_holds: assert property ($fell(diag.group_low[13]) || $fell(diag.group_high[13])
    |-> s_after_frame) else $error("open load cleared without frame");
  a_first_word: assert property (!framed_q |-> (diag.group_low & 16'hbffe) == 16'h0
    && (diag.group_high & 16'hbffe) == 16'h0) else $error("first word not masked");
  a_status_live: assert property ((framed_q && $stable(sense)) [*6]
    |-> diag.group_low[12:1] == {sense.high_side_switch[5:0] | sense.low_side_switch[5:0],
    sense.high_side_switch[5:0] & ~sense.low_side_switch[5:0]}) else $error("status bits wrong");
endmodule
bind half_bridge_diag_status diag_chk u_diag_chk (.core_clk, .reset, .chip_select_n, .sense,
  .drive, .diag);

// ---- verif/host_model.sv ----
// Purpose: Host side of the control link, one control word per frame.
// Assumes: The serial shifter is reduced to a word with a done pulse.
// Notes: The link clock stands still outside frames.
`timescale 1ns/1ns
module host_model (
  output logic link_clk,
  output logic chip_select_n,
  output logic [15:0] link_ctrl_word,
  output logic link_word_done
);
  initial begin
    link_clk = 1'b0;
    chip_select_n = 1'b1;
    link_ctrl_word = 16'h0000;
    link_word_done = 1'b0;
  end
  task automatic tick;
    #16 link_clk = 1'b1;
    #16 link_clk = 1'b0;
  endtask
  // After the done pulse the lane carries the inverse, so a late capture is caught.
  task automatic send(input logic [15:0] w, input int slow);
    chip_select_n = 1'b0;
    repeat (slow + 1) tick();
    link_ctrl_word = w;
    link_word_done = 1'b1;
    tick();
    link_ctrl_word = ~w;
    link_word_done = 1'b0;
    tick();
    chip_select_n = 1'b1;
  endtask
endmodule

// ---- verif/half_bridge_diag_status_test.sv ----
// Purpose: Directed checks of the diagnosis words and the protective switch-off.
// Assumes: Sense feedback differs from the command so echoes are caught.
// Notes: Each step waits eight core cycles, above the documented latency.
`timescale 1ns/1ns
module half_bridge_diag_status_test;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic link_clk, chip_select_n, link_word_done;
  logic [15:0] link_ctrl_word;
  diag_pkg::sense_s sense = '0;
  diag_pkg::drive_s drive;
  diag_pkg::diag_s diag;
  int fails = 0;
  int tests_run = 0;
  always #5 core_clk = ~core_clk;
  host_model u_host_model (.link_clk, .chip_select_n, .link_ctrl_word, .link_word_done);
  half_bridge_diag_status u_half_bridge_diag_status (.core_clk, .reset, .link_clk,
    .chip_select_n, .link_ctrl_word, .link_word_done, .sense, .drive, .diag);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic words(input string n, input logic [15:0] lo, input logic [15:0] hi,
    input logic [19:0] dr);
    step(8);
    check(n, {diag, 12'h000, drive}, {lo, hi, 12'h000, dr});
    $display("test %s done", n);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    step(20000);
    fails++;
    end_of_test();
  end
  initial begin
    step(2);
    reset = 1'b0;
    sense.load_supply_fault = 1'b1;
    sense.temp_warning = 1'b1;
    sense.high_side_switch = 10'h3ff;
    words("first", 16'h4001, 16'h4001, 20'h0_0000);
    sense = '0;
    sense.high_side_switch = 10'h243;
    sense.low_side_switch = 10'h184;
    words("quiet", 16'h0000, 16'h0000, 20'h0_0000);
    u_host_model.send(16'h1fd4, 3);
    words("low cmd", 16'h0386, 16'h0792, 20'h0_a815);
    u_host_model.send(16'h478a, 0);
    words("high cmd", 16'h0386, 16'h0792, 20'h5_aa95);
    sense.overcurrent = 10'h004;
    step(8);
    sense.overcurrent = 10'h000;
    words("oc latch", 16'h8386, 16'h0792, 20'h5_aa91);
    u_host_model.send(16'hc78a, 0);
    words("oc other", 16'h8386, 16'h0792, 20'h5_aa91);
    u_host_model.send(16'h9fd4, 0);
    words("oc clear", 16'h0386, 16'h0792, 20'h5_aa95);
    sense.open_load = 10'h001;
    step(8);
    sense.open_load = 10'h000;
    words("ol keep", 16'h2386, 16'h0792, 20'h5_aa95);
    u_host_model.send(16'h3fd4, 0);
    words("ol off", 16'h2386, 16'h0792, 20'h5_aa94);
    u_host_model.send(16'hbfd4, 0);
    words("ol clear", 16'h0386, 16'h0792, 20'h5_aa95);
    sense.load_supply_fault = 1'b1;
    sense.temp_warning = 1'b1;
    words("psf", 16'h4387, 16'h4793, 20'h0_0000);
    sense.load_supply_fault = 1'b0;
    words("psf gone", 16'h0387, 16'h0793, 20'h5_aa95);
    // A mid-run reset must drop both latches even though no status reset was sent.
    sense.overcurrent = 10'h200;
    sense.open_load = 10'h040;
    step(8);
    reset = 1'b1;
    sense.overcurrent = 10'h000;
    sense.open_load = 10'h000;
    step(2);
    reset = 1'b0;
    words("reset masked", 16'h4001 & 16'h0001, 16'h0001, 20'h0_0000);
    u_host_model.send(16'h0000, 0);
    words("reset clear", 16'h0387, 16'h0793, 20'h0_0000);
    end_of_test();
  end
endmodule
